// *** rtl/port_io_pkg.sv ***
package port_io_pkg;
  // register offsets on the plain register port
  localparam logic [4:0] ten_pin_pullup_low_byte_addr = 5'h00;
  localparam logic [4:0] ten_pin_pullup_high_byte_addr = 5'h01;
  localparam logic [4:0] three_pin_data_addr = 5'h02;
  localparam logic [4:0] three_pin_direction_addr = 5'h03;
  localparam logic [4:0] three_pin_alt_select_addr = 5'h04;
  localparam logic [4:0] three_pin_pullup_select_addr = 5'h05;
  localparam logic [4:0] six_pin_data_addr = 5'h06;
  localparam logic [4:0] six_pin_direction_addr = 5'h07;
  localparam logic [4:0] six_pin_alt_select_addr = 5'h08;
  localparam logic [4:0] six_pin_function_control_addr = 5'h09;
  localparam logic [4:0] six_pin_function_control_ext_addr = 5'h0a;
  localparam logic [4:0] six_pin_pullup_select_addr = 5'h0b;
  localparam logic [4:0] debug_mode_register_addr = 5'h0c;
  localparam logic [4:0] ten_pin_pullup_word_addr = 5'h10;

  localparam int ten_pin_width = 10;
  localparam int three_pin_width = 3;
  localparam int six_pin_width = 6;
  localparam int debug_mode_enable_pos = 0;

  localparam logic [15:0] ten_pin_pullup_reset = 16'h0000;
  localparam logic [7:0] direction_reset = 8'hff;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic debug_mode_enable_reset = 1'b1;

  // write access width: whole 16-bit word, one byte, or one bit
  typedef enum logic [1:0] {
    access_word = 2'h0,
    access_byte = 2'h1,
    access_bit = 2'h2
  } access_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    access_t size;
    logic [2:0] bit_index;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] dout;
    logic [2:0] oe;
    logic [2:0] pullup_en;
  } three_pin_drive_t;

  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe;
    logic [5:0] pullup_en;
  } six_pin_drive_t;
endpackage

// *** rtl/port_byte_reg.sv ***
`timescale 1ns/1ps
// one byte register with byte or single-bit write, constant fixed bits
module port_byte_reg
  import port_io_pkg::*;
#(
  parameter logic [7:0] reset_value = 8'h00,
  parameter logic [7:0] fixed_mask = 8'h00,
  parameter logic [7:0] fixed_value = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic write_en,
  input wire access_t size,
  input wire logic [2:0] bit_index,
  input wire logic [7:0] wdata,
  output logic [7:0] value
);
  logic [7:0] next_value;

  always_comb begin
    next_value = value;
    if (size == access_bit) begin
      next_value[bit_index] = wdata[0];
    end else begin
      next_value = wdata;
    end
    next_value = (next_value & ~fixed_mask) | (fixed_value & fixed_mask);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      value <= reset_value;
    end else if (write_en) begin
      value <= next_value;
    end
  end
endmodule

// *** rtl/port_io_pullup_control.sv ***
`timescale 1ns/1ps
// What this block does
// [R1] ten-pin pull-up register, word or bit access
// [R2] upper and lower bytes reachable as byte registers
// [R3] pull-up bit one connects, zero disconnects
// [R4] three-pin port, per-pin data/direction/mode/pull-up
// [R5] three-pin data reads pins, writes latches
// [R6] three-pin direction resets ones, bits 7-3 read one
// [R7] direction one means input, driver off
// [R8] mode registers choose port or alternate per pin
// [R9] three-pin alternate: serial in, out, clock
// [R10] three-pin pull-up resets zero, bits 7-3 zero
// [R11] six-pin port, per-pin data/direction/mode/pull-up
// [R12] six-pin function variant via two control registers
// [R13] six-pin alternate: key, timer, debug pins
// [R14] software clears debug enable, debug reset low
// [R15] debug reset low keeps pins as port; here pins with alternate select set stay alternate
// [R16] debug reset pull-down off once enable cleared
// [R17] six-pin data reads pins, writes latches
// [R18] six-pin direction register, per-pin input/output
module port_io_pullup_control
  import port_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire reg_req_t reg_req,
  output logic [15:0] rdata,
  input wire logic [9:0] ten_pin_level,
  output logic [9:0] ten_pin_pullup_en,
  input wire logic [2:0] three_pin_in,
  output three_pin_drive_t three_pin_drive,
  input wire logic [2:0] serial_dout,
  input wire logic [2:0] serial_oe,
  output logic [2:0] serial_din,
  input wire logic [5:0] six_pin_in,
  output six_pin_drive_t six_pin_drive,
  output logic [7:0] six_pin_function_control,
  output logic [7:0] six_pin_function_control_ext,
  output logic [5:0] key_return_input,
  output logic [3:0] timer_capture_input,
  input wire logic [3:0] timer_compare_output,
  input wire logic [3:0] timer_compare_oe,
  input wire logic [3:0] debug_dout,
  input wire logic [3:0] debug_oe,
  output logic [3:0] debug_din,
  output logic debug_pins_active,
  input wire logic debug_reset_input,
  output logic debug_reset_pulldown_en
);
  logic [7:0] ten_lo;
  logic [7:0] ten_hi;
  logic [7:0] three_pin_data;
  logic [7:0] three_pin_direction;
  logic [7:0] three_pin_alt_select;
  logic [7:0] three_pin_pullup_select;
  logic [7:0] six_pin_data;
  logic [7:0] six_pin_direction;
  logic [7:0] six_pin_alt_select;
  logic [7:0] six_pin_pullup_select;
  logic debug_mode_enable_bit;
  logic [15:0] next_rdata;
  logic word_wr;
  logic [4:0] a;
  logic [7:0] wb;
  logic [7:0] wb_hi;
  logic [2:0] idx_hi;
  logic lo_we;
  logic hi_we;
  access_t hi_size;

  assign a = reg_req.addr;
  assign wb = reg_req.wdata[7:0];
  assign word_wr = reg_req.wr && a == ten_pin_pullup_word_addr;

  // word writes land both bytes; a bit write in word mode goes to the upper byte
  // when wdata bit 15 is set, else to the lower byte, at the same bit index
  always_comb begin
    lo_we = 1'b0;
    hi_we = 1'b0;
    hi_size = reg_req.size;
    idx_hi = reg_req.bit_index;
    wb_hi = wb;
    if (reg_req.wr && a == ten_pin_pullup_low_byte_addr) begin // R2
      lo_we = 1'b1;
    end
    if (reg_req.wr && a == ten_pin_pullup_high_byte_addr) begin // R2
      hi_we = 1'b1;
    end
    if (word_wr) begin // R1
      if (reg_req.size == access_bit) begin
        lo_we = !reg_req.wdata[15];
        hi_we = reg_req.wdata[15];
        wb_hi = {7'h00, reg_req.wdata[0]};
      end else begin
        lo_we = 1'b1;
        hi_we = 1'b1;
        hi_size = access_byte;
        wb_hi = reg_req.wdata[15:8];
      end
    end
  end

  port_byte_reg #(.reset_value(ten_pin_pullup_reset[7:0])) u_ten_lo (
    .core_clk(core_clk), .rst_b(rst_b), .write_en(lo_we),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(ten_lo));
  port_byte_reg #(.reset_value(ten_pin_pullup_reset[15:8]),
    .fixed_mask(8'hfc)) u_ten_hi (
    .core_clk(core_clk), .rst_b(rst_b), .write_en(hi_we),
    .size(hi_size), .bit_index(idx_hi),
    .wdata(word_wr && reg_req.size != access_bit ? wb_hi : wb),
    .value(ten_hi));
  port_byte_reg #(.fixed_mask(8'hf8)) u_three_data ( // R5
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == three_pin_data_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(three_pin_data));
  port_byte_reg #(.reset_value(direction_reset), .fixed_mask(8'hf8),
    .fixed_value(8'hf8)) u_three_dir ( // R6
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == three_pin_direction_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(three_pin_direction));
  port_byte_reg #(.fixed_mask(8'hf8)) u_three_alt ( // R8
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == three_pin_alt_select_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(three_pin_alt_select));
  port_byte_reg #(.reset_value(byte_reset), .fixed_mask(8'hf8)) u_three_pu (
    .core_clk(core_clk), .rst_b(rst_b), // R10
    .write_en(reg_req.wr && a == three_pin_pullup_select_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(three_pin_pullup_select));
  port_byte_reg #(.fixed_mask(8'hc0)) u_six_data ( // R17
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == six_pin_data_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(six_pin_data));
  port_byte_reg #(.reset_value(direction_reset), .fixed_mask(8'hc0),
    .fixed_value(8'hc0)) u_six_dir ( // R18
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == six_pin_direction_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(six_pin_direction));
  port_byte_reg #(.fixed_mask(8'hc0)) u_six_alt ( // R8
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == six_pin_alt_select_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(six_pin_alt_select));
  port_byte_reg #(.fixed_mask(8'hc0)) u_six_pfc ( // R12
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == six_pin_function_control_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(six_pin_function_control));
  port_byte_reg #(.fixed_mask(8'hf0)) u_six_pfce ( // R12
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == six_pin_function_control_ext_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(six_pin_function_control_ext));
  port_byte_reg #(.fixed_mask(8'hc0)) u_six_pu (
    .core_clk(core_clk), .rst_b(rst_b),
    .write_en(reg_req.wr && a == six_pin_pullup_select_addr),
    .size(reg_req.size), .bit_index(reg_req.bit_index),
    .wdata(wb), .value(six_pin_pullup_select));

  // debug enable is set by every reset and only cleared by software
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      debug_mode_enable_bit <= debug_mode_enable_reset;
    end else if (reg_req.wr && a == debug_mode_register_addr &&
                 (reg_req.size != access_bit ||
                  reg_req.bit_index == 3'(debug_mode_enable_pos))) begin
      debug_mode_enable_bit <= reg_req.wdata[debug_mode_enable_pos];
    end
  end

  // a low debug reset keeps the shared pins out of debug use regardless; alternate select still routes them
  assign debug_pins_active = debug_mode_enable_bit && debug_reset_input; // R15
  assign debug_reset_pulldown_en = debug_mode_enable_bit; // R16

  assign ten_pin_pullup_en = {ten_hi[1:0], ten_lo}; // R3

  // three-pin port: alternate pins hand the driver to the serial unit
  always_comb begin
    for (int i = 0; i < three_pin_width; i++) begin
      if (three_pin_alt_select[i]) begin // R9
        three_pin_drive.dout[i] = serial_dout[i];
        three_pin_drive.oe[i] = serial_oe[i];
      end else begin
        three_pin_drive.dout[i] = three_pin_data[i]; // R4
        three_pin_drive.oe[i] = !three_pin_direction[i]; // R7
      end
      // pull-up only helps a pin that is not being driven
      three_pin_drive.pullup_en[i] = three_pin_pullup_select[i] &&
                                     !three_pin_drive.oe[i];
    end
  end
  assign serial_din = three_pin_in;

  // padded to six bits so that every pin index stays in range when unrolled
  logic [5:0] debug_dout_wide;
  logic [5:0] debug_oe_wide;
  logic [5:0] timer_dout_wide;
  logic [5:0] timer_oe_wide;
  assign debug_dout_wide = {debug_dout, 2'b00};
  assign debug_oe_wide = {debug_oe, 2'b00};
  assign timer_dout_wide = {2'b00, timer_compare_output};
  assign timer_oe_wide = {2'b00, timer_compare_oe};

  // six-pin port: debug overrides alternate, alternate overrides port
  always_comb begin
    for (int i = 0; i < six_pin_width; i++) begin
      if (debug_pins_active && i >= 2) begin // R13
        six_pin_drive.dout[i] = debug_dout_wide[i];
        six_pin_drive.oe[i] = debug_oe_wide[i];
      end else if (six_pin_alt_select[i] && i < 4 &&
                   six_pin_function_control_ext[i]) begin // R12
        six_pin_drive.dout[i] = timer_dout_wide[i];
        six_pin_drive.oe[i] = timer_oe_wide[i];
      end else if (six_pin_alt_select[i]) begin // R13
        six_pin_drive.dout[i] = 1'b0;
        six_pin_drive.oe[i] = 1'b0;
      end else begin
        six_pin_drive.dout[i] = six_pin_data[i]; // R11
        six_pin_drive.oe[i] = !six_pin_direction[i]; // R7
      end
      six_pin_drive.pullup_en[i] = six_pin_pullup_select[i] &&
                                   !six_pin_drive.oe[i];
    end
  end
  assign key_return_input = six_pin_in & six_pin_alt_select[5:0]; // R13
  assign timer_capture_input = six_pin_in[3:0] & six_pin_alt_select[3:0];
  assign debug_din = debug_pins_active ? six_pin_in[5:2] : 4'h0;

  always_comb begin
    unique case (a)
      ten_pin_pullup_low_byte_addr: next_rdata = {8'h00, ten_lo};
      ten_pin_pullup_high_byte_addr: next_rdata = {8'h00, ten_hi};
      ten_pin_pullup_word_addr: next_rdata = {ten_hi, ten_lo}; // R1
      three_pin_data_addr: next_rdata = {13'h0000, three_pin_in}; // R5
      three_pin_direction_addr: next_rdata = {8'h00, three_pin_direction};
      three_pin_alt_select_addr: next_rdata = {8'h00, three_pin_alt_select};
      three_pin_pullup_select_addr:
        next_rdata = {8'h00, three_pin_pullup_select};
      six_pin_data_addr: next_rdata = {10'h000, six_pin_in}; // R17
      six_pin_direction_addr: next_rdata = {8'h00, six_pin_direction};
      six_pin_alt_select_addr: next_rdata = {8'h00, six_pin_alt_select};
      six_pin_function_control_addr:
        next_rdata = {8'h00, six_pin_function_control};
      six_pin_function_control_ext_addr:
        next_rdata = {8'h00, six_pin_function_control_ext};
      six_pin_pullup_select_addr: next_rdata = {8'h00, six_pin_pullup_select};
      debug_mode_register_addr: next_rdata = {15'h0000, debug_mode_enable_bit};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end

  property p_three_dir_high;
    @(posedge core_clk) disable iff (!rst_b)
      three_pin_direction[7:3] == 5'h1f;
  endproperty
  a_three_dir_high: assert property (p_three_dir_high) // R6
    else $error("three-pin direction upper bits not one");

  property p_three_pu_low;
    @(posedge core_clk) disable iff (!rst_b)
      three_pin_pullup_select[7:3] == 5'h00;
  endproperty
  a_three_pu_low: assert property (p_three_pu_low) // R10
    else $error("three-pin pull-up upper bits not zero");

  property p_input_no_drive;
    @(posedge core_clk) disable iff (!rst_b)
      (!six_pin_alt_select[0] && six_pin_direction[0]) |->
        !six_pin_drive.oe[0];
  endproperty
  a_input_no_drive: assert property (p_input_no_drive) // R7
    else $error("input pin driven");

  property p_word_read;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_req.rd && a == ten_pin_pullup_word_addr) |=>
        rdata == {$past(ten_hi), $past(ten_lo)};
  endproperty
  a_word_read: assert property (p_word_read) // R1
    else $error("ten-pin word read mismatch");

  property p_pins_port;
    @(posedge core_clk) disable iff (!rst_b)
      !debug_reset_input |-> !debug_pins_active;
  endproperty
  a_pins_port: assert property (p_pins_port) // R15
    else $error("debug pins active while debug reset low");

  property p_pulldown_off;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && a == debug_mode_register_addr &&
       (reg_req.size != access_bit || reg_req.bit_index == 3'h0) &&
       !reg_req.wdata[0]) |=>
        !debug_reset_pulldown_en;
  endproperty
  a_pulldown_off: assert property (p_pulldown_off) // R16
    else $error("debug reset pull-down still on");

  property p_three_read;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_req.rd && a == three_pin_data_addr) |=>
        rdata[2:0] == $past(three_pin_in) && rdata[15:3] == 13'h0000;
  endproperty
  a_three_read: assert property (p_three_read) // R5
    else $error("three-pin data read not pin level");

  property p_serial_alt;
    @(posedge core_clk) disable iff (!rst_b)
      three_pin_alt_select[1] |->
        three_pin_drive.oe[1] == serial_oe[1];
  endproperty
  a_serial_alt: assert property (p_serial_alt) // R9
    else $error("serial output not routed");

  property p_word_write;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && a == ten_pin_pullup_word_addr &&
       reg_req.size == access_word) |=>
        ten_pin_pullup_en == $past(reg_req.wdata[9:0]);
  endproperty
  a_word_write: assert property (p_word_write) // R3
    else $error("ten-pin pull-up word write not applied");

  property p_six_dir_write;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && a == six_pin_direction_addr &&
       reg_req.size == access_byte) |=>
        six_pin_direction == ($past(reg_req.wdata[7:0]) | 8'hc0);
  endproperty
  a_six_dir_write: assert property (p_six_dir_write) // R18
    else $error("six-pin direction write not applied");

  property p_debug_route;
    @(posedge core_clk) disable iff (!rst_b)
      debug_pins_active |->
        six_pin_drive.oe[5:2] == debug_oe &&
        six_pin_drive.dout[5:2] == debug_dout;
  endproperty
  a_debug_route: assert property (p_debug_route) // R13
    else $error("debug pins not routed");

  // no disable here: this one is about what reset itself leaves behind
  property p_debug_enable_reset;
    @(posedge core_clk)
      !rst_b |=> debug_reset_pulldown_en;
  endproperty
  a_debug_enable_reset: assert property (p_debug_enable_reset) // R16
    else $error("debug enable not set by reset");
endmodule

// *** test/pin_world.sv ***
`timescale 1ns/1ps
// outside world at the pins: a driven pin shows its driven value, a released one
// its pull-up, otherwise whatever the board puts on it
module pin_world
  import port_io_pkg::*;
(
  input wire three_pin_drive_t three_pin_drive,
  input wire six_pin_drive_t six_pin_drive,
  input wire logic [9:0] ten_pin_pullup_en,
  input wire logic debug_reset_pulldown_en,
  input wire logic [9:0] ten_ext,
  input wire logic [2:0] three_ext,
  input wire logic [5:0] six_ext,
  input wire logic debug_reset_input_drive,
  input wire logic debug_reset_input_level,
  output logic [9:0] ten_pin_level,
  output logic [2:0] three_pin_in,
  output logic [5:0] six_pin_in,
  output logic debug_reset_input
);
  assign ten_pin_level = ten_pin_pullup_en | ten_ext;
  assign three_pin_in = (three_pin_drive.oe & three_pin_drive.dout) |
    (~three_pin_drive.oe & (three_pin_drive.pullup_en | three_ext));
  assign six_pin_in = (six_pin_drive.oe & six_pin_drive.dout) |
    (~six_pin_drive.oe & (six_pin_drive.pullup_en | six_ext));
  // released line: pull-down holds it low, without it the line reads high
  assign debug_reset_input = debug_reset_input_drive ? debug_reset_input_level :
    !debug_reset_pulldown_en;
endmodule

// *** test/port_io_pullup_control_tb.sv ***
`timescale 1ns/1ps
module port_io_pullup_control_tb;
  import port_io_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t reg_req = '0;
  logic [15:0] rdata;
  logic [9:0] ten_pin_level, ten_pin_pullup_en, ten_ext = '0;
  logic [2:0] three_pin_in, serial_din, three_ext = '0;
  logic [2:0] serial_dout = '0, serial_oe = '0;
  three_pin_drive_t three_pin_drive;
  six_pin_drive_t six_pin_drive;
  logic [5:0] six_pin_in, key_return_input, six_ext = 6'h15;
  logic [7:0] six_pin_function_control, six_pin_function_control_ext;
  logic [3:0] timer_capture_input, debug_din;
  logic [3:0] timer_compare_output = '0, timer_compare_oe = '0;
  logic [3:0] debug_dout = '0, debug_oe = '0;
  logic debug_pins_active, debug_reset_input, debug_reset_pulldown_en;
  logic debug_reset_input_drive = 1'b1, debug_reset_input_level = 1'b0;
  int n_fail = 0;
  int n_tests = 0;

  always #20 core_clk = ~core_clk;

  port_io_pullup_control dut (.core_clk, .rst_b, .reg_req, .rdata,
    .ten_pin_level, .ten_pin_pullup_en, .three_pin_in, .three_pin_drive,
    .serial_dout, .serial_oe, .serial_din, .six_pin_in, .six_pin_drive,
    .six_pin_function_control, .six_pin_function_control_ext,
    .key_return_input, .timer_capture_input, .timer_compare_output,
    .timer_compare_oe, .debug_dout, .debug_oe, .debug_din,
    .debug_pins_active, .debug_reset_input, .debug_reset_pulldown_en);

  pin_world world (.three_pin_drive, .six_pin_drive, .ten_pin_pullup_en,
    .debug_reset_pulldown_en, .ten_ext, .three_ext, .six_ext, .debug_reset_input_drive,
    .debug_reset_input_level, .ten_pin_level, .three_pin_in, .six_pin_in,
    .debug_reset_input);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input access_t s,
                    input logic [2:0] b, input logic [15:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.size <= s;
    reg_req.bit_index <= b;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic t_reset();
    rchk(three_pin_direction_addr, 16'h00ff);
    rchk(three_pin_pullup_select_addr, 16'h0000);
    rchk(six_pin_direction_addr, 16'h00ff);
    rchk(ten_pin_pullup_word_addr, 16'h0000);
    rchk(debug_mode_register_addr, 16'h0001);
    chk({13'h0, three_pin_drive.oe}, 16'h0000);
    chk({15'h0, debug_reset_pulldown_en}, 16'h0001);
    $display("done reset");
  endtask

  task automatic t_ten();
    wr(ten_pin_pullup_word_addr, access_word, 3'd0, 16'hffff);
    rchk(ten_pin_pullup_word_addr, 16'h03ff);
    chk({6'h0, ten_pin_pullup_en}, 16'h03ff);
    wr(ten_pin_pullup_high_byte_addr, access_byte, 3'd0, 16'h0000);
    rchk(ten_pin_pullup_word_addr, 16'h00ff);
    rchk(ten_pin_pullup_low_byte_addr, 16'h00ff);
    wr(ten_pin_pullup_high_byte_addr, access_bit, 3'd1, 16'h0001);
    rchk(ten_pin_pullup_high_byte_addr, 16'h0002);
    chk({6'h0, ten_pin_pullup_en}, 16'h02ff);
    wr(ten_pin_pullup_word_addr, access_bit, 3'd0, 16'h8001);
    wr(ten_pin_pullup_word_addr, access_bit, 3'd4, 16'h0000);
    rchk(ten_pin_pullup_word_addr, 16'h03ef);
    chk({6'h0, ten_pin_pullup_en}, 16'h03ef);
    $display("done ten pin");
  endtask

  task automatic t_three();
    wr(three_pin_direction_addr, access_byte, 3'd0, 16'h0000);
    rchk(three_pin_direction_addr, 16'h00f8);
    chk({13'h0, three_pin_drive.oe}, 16'h0007);
    wr(three_pin_data_addr, access_byte, 3'd0, 16'h0005);
    chk({13'h0, three_pin_drive.dout}, 16'h0005);
    wr(three_pin_direction_addr, access_bit, 3'd2, 16'h0001);
    chk({13'h0, three_pin_drive.oe}, 16'h0003);
    rchk(three_pin_data_addr, 16'h0001);
    wr(three_pin_pullup_select_addr, access_byte, 3'd0, 16'h00ff);
    rchk(three_pin_pullup_select_addr, 16'h0007);
    chk({13'h0, three_pin_drive.pullup_en}, 16'h0004);
    rchk(three_pin_data_addr, 16'h0005);
    wr(three_pin_direction_addr, access_bit, 3'd7, 16'h0000);
    rchk(three_pin_direction_addr, 16'h00fc);
    $display("done three pin");
  endtask

  task automatic t_serial();
    @(posedge core_clk);
    serial_dout <= 3'b010;
    serial_oe <= 3'b010;
    wr(three_pin_alt_select_addr, access_byte, 3'd0, 16'h0007);
    rchk(three_pin_alt_select_addr, 16'h0007);
    chk({13'h0, three_pin_drive.oe}, 16'h0002);
    chk({13'h0, serial_din}, 16'h0007);
    wr(three_pin_alt_select_addr, access_byte, 3'd0, 16'h0000);
    $display("done serial");
  endtask

  task automatic t_six();
    wr(six_pin_direction_addr, access_byte, 3'd0, 16'h0000);
    rchk(six_pin_direction_addr, 16'h00c0);
    chk({10'h0, six_pin_drive.oe}, 16'h003f);
    wr(six_pin_data_addr, access_byte, 3'd0, 16'h002a);
    wr(six_pin_data_addr, access_bit, 3'd0, 16'h0001);
    rchk(six_pin_data_addr, 16'h002b);
    wr(six_pin_direction_addr, access_byte, 3'd0, 16'h00ff);
    rchk(six_pin_data_addr, 16'h0015);
    wr(six_pin_pullup_select_addr, access_byte, 3'd0, 16'h0003);
    chk({10'h0, six_pin_drive.pullup_en}, 16'h0003);
    rchk(six_pin_data_addr, 16'h0017);
    wr(six_pin_alt_select_addr, access_byte, 3'd0, 16'h003f);
    rchk(six_pin_alt_select_addr, 16'h003f);
    chk({10'h0, key_return_input}, 16'h0017);
    chk({12'h0, timer_capture_input}, 16'h0007);
    wr(six_pin_function_control_addr, access_byte, 3'd0, 16'h00a5);
    rchk(six_pin_function_control_addr, 16'h0025);
    chk({8'h0, six_pin_function_control}, 16'h0025);
    @(posedge core_clk);
    timer_compare_output <= 4'ha;
    timer_compare_oe <= 4'hf;
    wr(six_pin_function_control_ext_addr, access_byte, 3'd0, 16'h00ff);
    rchk(six_pin_function_control_ext_addr, 16'h000f);
    chk({8'h0, six_pin_function_control_ext}, 16'h000f);
    chk({12'h0, six_pin_in[3:0]}, 16'h000a);
    wr(six_pin_alt_select_addr, access_byte, 3'd0, 16'h0000);
    $display("done six pin");
  endtask

  task automatic t_debug();
    @(posedge core_clk);
    debug_dout <= 4'h5;
    debug_oe <= 4'hf;
    debug_reset_input_level <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({15'h0, debug_pins_active}, 16'h0001);
    chk({12'h0, six_pin_in[5:2]}, 16'h0005);
    chk({12'h0, debug_din}, 16'h0005);
    // release the line: only the on-chip pull-down now keeps it low
    @(posedge core_clk);
    debug_reset_input_drive <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({15'h0, debug_reset_input}, 16'h0000);
    chk({15'h0, debug_pins_active}, 16'h0000);
    wr(debug_mode_register_addr, access_bit, 3'd0, 16'h0000);
    rchk(debug_mode_register_addr, 16'h0000);
    chk({15'h0, debug_reset_pulldown_en}, 16'h0000);
    chk({15'h0, debug_pins_active}, 16'h0000);
    rchk(5'h1f, 16'h0000);
    $display("done debug");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ten();
    t_three();
    t_serial();
    t_six();
    t_debug();
    end_of_test();
  end

  // cut a hang short
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
endmodule
